/* serdes_prov_pkg.sv */
// Constants and types for the dual-channel provisioning register bank.
// Assumes a single core clock domain; MDIO arrives as sampled pins.
`default_nettype none
package serdes_prov_pkg;
  // ----------------------------------------
  // Register offsets (MDIO register address)
  // ----------------------------------------
  localparam logic [4:0] REG_GLOBAL = 5'h00;
  localparam logic [4:0] REG_RATE = 5'h01;
  localparam logic [4:0] REG_EMPH = 5'h02;
  localparam logic [4:0] REG_ALIGN = 5'h03;
  localparam logic [4:0] REG_DPRST = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h05;
  localparam logic [4:0] REG_OVL = 5'h06;
  localparam logic [4:0] REG_OVLX = 5'h07;
  localparam logic [4:0] REG_EQ = 5'h08;
  localparam logic [4:0] REG_RXEN = 5'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GL_SOFT_RST = 15;
  localparam int GL_GWRITE = 11;
  localparam int GL_REF_A = 1;
  localparam int GL_REF_B = 0;
  localparam int RATE_TX_LSB = 6;
  localparam int RATE_RX_LSB = 4;
  localparam int LOOP_LSB = 8;
  localparam int MULT_LSB = 0;
  localparam int POST_LSB = 8;
  localparam int PRE_LSB = 4;
  localparam int SWING_LSB = 0;
  localparam int ALN_COMMA = 8;
  localparam int ALN_TENBIT = 7;
  localparam int ALN_DDR = 6;
  localparam int ALN_TXEDGE = 1;
  localparam int ALN_RXEDGE = 0;
  localparam int DP_CLEAR = 3;
  localparam int OVL_LOS = 10;
  localparam int OVL_SYNC = 9;
  localparam int OVL_LOCK = 8;
  localparam int OVL_TERM_LSB = 0;
  localparam int OVL_SLEW = 2;
  localparam int OVLX_AGC = 7;
  localparam int OVLX_AZ = 6;
  localparam int EQ_PRE_LSB = 12;
  localparam int EQ_THR_LSB = 10;
  localparam int EQ_FM_LSB = 8;
  localparam int RXEN_ON = 2;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] RST_GLOBAL = 16'h0000;
  localparam logic [15:0] RST_RATE = 16'h010E;
  localparam logic [15:0] RST_EMPH = 16'h0000;
  localparam logic [15:0] RST_ALIGN = 16'h0180;
  localparam logic [15:0] RST_DPRST = 16'h0000;
  localparam logic [15:0] RST_OVL = 16'h0000;
  localparam logic [15:0] RST_OVLX = 16'h0000;
  localparam logic [15:0] RST_EQ = 16'h0400;
  localparam logic [15:0] RST_RXEN = 16'h0004;
  localparam logic [3:0] MULT_25X = 4'hE;
  localparam logic [3:0] MULT_20X = 4'hD;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0C;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DIV_FULL = 2'b00, DIV_HALF = 2'b01,
    DIV_QUARTER = 2'b10, DIV_EIGHTH = 2'b11
  } rate_div_t;
  typedef enum logic [1:0] {
    MUL_NONE = 2'b00, MUL_X20 = 2'b01, MUL_X25 = 2'b10
  } mult_t;
  typedef enum logic [2:0] {
    F_PRE = 3'b000, F_HDR = 3'b001, F_TA = 3'b010,
    F_WR = 3'b011, F_RD = 3'b100
  } frame_t;
  typedef struct packed {
    logic autozero_complete;
    logic gain_loop_settled;
    logic tx_under;
    logic tx_over;
    logic rx_under;
    logic rx_over;
    logic signal_absent;
    logic sync;
    logic pll_lock;
  } chan_stat_t;
  typedef struct packed {
    logic ref_sel;
    rate_div_t tx_rate;
    rate_div_t rx_rate;
    mult_t mult;
    logic [1:0] loop_width;
    logic [4:0] post;
    logic [3:0] pre;
    logic [3:0] swing;
    logic [2:0] eq_preset;
    logic [1:0] rec_thr;
    logic [1:0] rec_fmult;
    logic [1:0] term;
    logic slew;
    logic receiver_on;
    logic comma_en;
    logic ten_bit;
    logic ddr_en;
    logic tx_edge;
    logic rx_edge;
    logic path_clear;
  } chan_cfg_t;
endpackage : serdes_prov_pkg
`default_nettype wire

/* serdes_channel_provisioning.sv */
// MDIO-managed provisioning registers for two transceiver channels.
// Assumes MDC/MDIO from an asynchronous host; status from analog core.
//
// Function
// RL1 - Board straps pins for software control first
// RL2 - Reset pin or soft bit resets device
// RL3 - Global write updates both channels together
// RL4 - Register zero selects reference per channel
// RL5 - Decode transmit and receive rate divider
// RL6 - Decode multiplier patterns 25x and 20x
// RL7 - Host writes whole rate word per rate
// RL8 - Host sets recovery threshold and multiplier
// RL9 - Emphasis, equaliser, loop width applied from registers
// RL10 - Comma sync and ten-bit alignment default on
// RL11 - Align mode default single-rate falling edge
// RL12 - Overlay bits route status to pins
// RL13 - Host polls lock then toggles receiver
// RL14 - Host waits gain lock, updates multiplier
// RL15 - Datapath clear bit resets parallel path
// RL16 - Status read clears latched bits
// RL17 - Status register bit layout as defined
// RL18 - Termination strength selected per channel
// RL19 - Output slew selected by one bit
// RL20 - Latched-high bits hold until read
// RL21 - Clear-on-read values return zero after read
// RL22 - Status pin is OR of enabled conditions
// RL23 - Lock bit reads live state
`default_nettype none
module serdes_channel_provisioning #(
  parameter logic [3:0] PHY_BASE = 4'h0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // Channel conditions, index 0 is channel A
  input wire serdes_prov_pkg::chan_stat_t stat_a,
  input wire serdes_prov_pkg::chan_stat_t stat_b,
  // Channel settings
  output serdes_prov_pkg::chan_cfg_t cfg_a,
  output serdes_prov_pkg::chan_cfg_t cfg_b,
  output logic status_pin_a,
  output logic status_pin_b
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] reg_slot(input logic [4:0] a);
    unique case (a)
      serdes_prov_pkg::REG_RATE: reg_slot = 4'h8;
      serdes_prov_pkg::REG_EMPH: reg_slot = 4'h9;
      serdes_prov_pkg::REG_ALIGN: reg_slot = 4'hA;
      serdes_prov_pkg::REG_DPRST: reg_slot = 4'hB;
      serdes_prov_pkg::REG_OVL: reg_slot = 4'hC;
      serdes_prov_pkg::REG_OVLX: reg_slot = 4'hD;
      serdes_prov_pkg::REG_EQ: reg_slot = 4'hE;
      serdes_prov_pkg::REG_RXEN: reg_slot = 4'hF;
      default: reg_slot = 4'h0;
    endcase
  endfunction : reg_slot

  function automatic logic [15:0] stat_word(
    input serdes_prov_pkg::chan_stat_t l,
    input serdes_prov_pkg::chan_stat_t c);
    serdes_prov_pkg::chan_stat_t v;
    logic [15:0] w;
    v = l | c;
    w = 16'h0000;
    w[14] = v.autozero_complete; // RL17
    w[13] = v.gain_loop_settled;
    w[7] = v.tx_under;
    w[6] = v.tx_over;
    w[5] = v.rx_under;
    w[4] = v.rx_over;
    w[2] = v.signal_absent;
    w[1] = v.sync;
    w[0] = c.pll_lock; // RL23
    stat_word = w;
  endfunction : stat_word

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] mdc_ff;
  logic [1:0] mdio_ff;
  serdes_prov_pkg::chan_stat_t s1_ff [2];
  serdes_prov_pkg::chan_stat_t cond [2];
  logic rise;

  always_ff @(posedge core_clk) begin
    mdc_ff <= {mdc_ff[1:0], mdc};
    mdio_ff <= {mdio_ff[0], mdio_in};
    s1_ff[0] <= stat_a;
    s1_ff[1] <= stat_b;
    cond <= s1_ff;
  end
  assign rise = mdc_ff[1] & ~mdc_ff[2];

  // ----------------------------------------
  // MDIO frame engine
  // ----------------------------------------
  serdes_prov_pkg::frame_t st_ff, nxt_st;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [15:0] sh_ff, nxt_sh, rd_ff, nxt_rd;
  logic [4:0] adr_ff, nxt_adr;
  logic ch_ff, nxt_ch, op_rd_ff, nxt_op_rd;
  logic out_ff, nxt_out, oe_n_ff, nxt_oe_n;
  logic wr_go, rd_go, din;
  logic [12:0] hdr;
  logic [15:0] wr_data, rd_val;
  logic [15:0] glob_ff, nxt_glob;
  logic [15:0] regs_ff [2][8];
  logic [15:0] nxt_regs [2][8];
  serdes_prov_pkg::chan_stat_t lat_ff [2];
  serdes_prov_pkg::chan_stat_t nxt_lat [2];
  logic [1:0] rd_clr;

  assign din = mdio_ff[1];
  assign hdr = {sh_ff[11:0], din};
  assign wr_data = {sh_ff[14:0], din};

  // Read data is snapshotted the moment the header completes
  always_comb begin
    logic [3:0] s;
    s = reg_slot(hdr[4:0]);
    rd_val = 16'h0000;
    if (hdr[4:0] == serdes_prov_pkg::REG_GLOBAL) begin
      rd_val = glob_ff;
    end else if (hdr[4:0] == serdes_prov_pkg::REG_STAT) begin
      rd_val = stat_word(lat_ff[hdr[5]], cond[hdr[5]]);
    end else if (s[3]) begin
      rd_val = regs_ff[hdr[5]][s[2:0]];
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rd = rd_ff;
    nxt_adr = adr_ff;
    nxt_ch = ch_ff;
    nxt_op_rd = op_rd_ff;
    nxt_out = out_ff;
    nxt_oe_n = oe_n_ff;
    wr_go = 1'b0;
    rd_go = 1'b0;
    if (rise) begin
      unique case (st_ff)
        serdes_prov_pkg::F_PRE: begin
          if (din) begin
            if (cnt_ff != serdes_prov_pkg::PRE_LEN) nxt_cnt = cnt_ff + 6'h01;
          end else if (cnt_ff == serdes_prov_pkg::PRE_LEN) begin
            nxt_st = serdes_prov_pkg::F_HDR;
            nxt_cnt = 6'h00;
          end else begin
            nxt_cnt = 6'h00;
          end
        end
        serdes_prov_pkg::F_HDR: begin
          nxt_sh = wr_data;
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == serdes_prov_pkg::HDR_LAST) begin
            nxt_cnt = 6'h00;
            nxt_adr = hdr[4:0];
            nxt_ch = hdr[5];
            nxt_op_rd = (hdr[11:10] == serdes_prov_pkg::OP_RD);
            if (hdr[12] && hdr[9:6] == PHY_BASE &&
                (hdr[11:10] == serdes_prov_pkg::OP_RD ||
                 hdr[11:10] == serdes_prov_pkg::OP_WR)) begin
              nxt_st = serdes_prov_pkg::F_TA;
              rd_go = (hdr[11:10] == serdes_prov_pkg::OP_RD);
              nxt_rd = rd_val;
            end else begin
              nxt_st = serdes_prov_pkg::F_PRE;
            end
          end
        end
        serdes_prov_pkg::F_TA: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h00) begin
            nxt_oe_n = ~op_rd_ff;
            nxt_out = 1'b0;
          end else begin
            nxt_cnt = 6'h00;
            nxt_st = op_rd_ff ? serdes_prov_pkg::F_RD : serdes_prov_pkg::F_WR;
            nxt_out = rd_ff[15];
            nxt_rd = {rd_ff[14:0], 1'b0};
          end
        end
        serdes_prov_pkg::F_WR: begin
          nxt_sh = wr_data;
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == serdes_prov_pkg::DATA_LAST) begin
            wr_go = 1'b1;
            nxt_cnt = 6'h00;
            nxt_st = serdes_prov_pkg::F_PRE;
          end
        end
        serdes_prov_pkg::F_RD: begin
          nxt_cnt = cnt_ff + 6'h01;
          nxt_out = rd_ff[15];
          nxt_rd = {rd_ff[14:0], 1'b0};
          if (cnt_ff == serdes_prov_pkg::DATA_LAST) begin
            nxt_oe_n = 1'b1;
            nxt_out = 1'b0;
            nxt_cnt = 6'h00;
            nxt_st = serdes_prov_pkg::F_PRE;
          end
        end
        default: begin
          nxt_st = serdes_prov_pkg::F_PRE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff <= serdes_prov_pkg::F_PRE;
      cnt_ff <= 6'h00;
      sh_ff <= 16'h0000;
      rd_ff <= 16'h0000;
      adr_ff <= 5'h00;
      ch_ff <= 1'b0;
      op_rd_ff <= 1'b0;
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rd_ff <= nxt_rd;
      adr_ff <= nxt_adr;
      ch_ff <= nxt_ch;
      op_rd_ff <= nxt_op_rd;
      out_ff <= nxt_out;
      oe_n_ff <= nxt_oe_n;
    end
  end

  // ----------------------------------------
  // Register file and latched status
  // ----------------------------------------
  logic soft_ff, nxt_soft;
  logic [1:0] clr_ff, nxt_clr;
  logic [3:0] wslot;
  logic [15:0] rst_val [8];

  assign wslot = reg_slot(adr_ff);
  assign rst_val = '{serdes_prov_pkg::RST_RATE, serdes_prov_pkg::RST_EMPH,
    serdes_prov_pkg::RST_ALIGN, serdes_prov_pkg::RST_DPRST, serdes_prov_pkg::RST_OVL,
    serdes_prov_pkg::RST_OVLX, serdes_prov_pkg::RST_EQ, serdes_prov_pkg::RST_RXEN};

  always_comb begin
    nxt_glob = glob_ff;
    nxt_regs = regs_ff;
    nxt_soft = 1'b0;
    nxt_clr = 2'b00;
    for (int c = 0; c < 2; c++) begin
      rd_clr[c] = rd_go && (hdr[5] == c[0]) && (hdr[4:0] == serdes_prov_pkg::REG_STAT);
      // Set wins: present condition survives the clearing read
      nxt_lat[c] = cond[c] | (rd_clr[c] ? '0 : lat_ff[c]); // RL16 RL20 RL21
    end
    if (wr_go && adr_ff == serdes_prov_pkg::REG_GLOBAL) begin
      nxt_glob = wr_data;
      nxt_glob[serdes_prov_pkg::GL_SOFT_RST] = 1'b0;
      nxt_soft = wr_data[serdes_prov_pkg::GL_SOFT_RST]; // RL2
    end
    for (int c = 0; c < 2; c++) begin
      if (wr_go && wslot[3] &&
          (ch_ff == c[0] || glob_ff[serdes_prov_pkg::GL_GWRITE])) begin // RL3
        nxt_regs[c][wslot[2:0]] = wr_data;
        if (adr_ff == serdes_prov_pkg::REG_DPRST) begin
          // Self-clearing; the pulse carries the effect
          nxt_regs[c][wslot[2:0]][serdes_prov_pkg::DP_CLEAR] = 1'b0;
          nxt_clr[c] = wr_data[serdes_prov_pkg::DP_CLEAR]; // RL15
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || soft_ff) begin // RL2
      glob_ff <= serdes_prov_pkg::RST_GLOBAL;
      for (int c = 0; c < 2; c++) begin
        regs_ff[c] <= rst_val;
        lat_ff[c] <= '0;
      end
      soft_ff <= 1'b0;
      clr_ff <= 2'b11;
    end else begin
      glob_ff <= nxt_glob;
      regs_ff <= nxt_regs;
      lat_ff <= nxt_lat;
      soft_ff <= nxt_soft;
      clr_ff <= nxt_clr;
    end
  end

  // ----------------------------------------
  // Decoded settings and status pins
  // ----------------------------------------
  serdes_prov_pkg::chan_cfg_t cfg_ff [2];
  serdes_prov_pkg::chan_cfg_t nxt_cfg [2];
  logic [1:0] pin_ff, nxt_pin;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      logic [15:0] r, e, a, o, x;
      r = regs_ff[c][0];
      e = regs_ff[c][1];
      a = regs_ff[c][2];
      o = regs_ff[c][4];
      x = regs_ff[c][5];
      nxt_cfg[c].ref_sel = glob_ff[c == 0 ? serdes_prov_pkg::GL_REF_A
                                          : serdes_prov_pkg::GL_REF_B]; // RL4
      nxt_cfg[c].tx_rate = serdes_prov_pkg::rate_div_t'(r[serdes_prov_pkg::RATE_TX_LSB +: 2]); // RL5
      nxt_cfg[c].rx_rate = serdes_prov_pkg::rate_div_t'(r[serdes_prov_pkg::RATE_RX_LSB +: 2]);
      nxt_cfg[c].mult = (r[3:0] == serdes_prov_pkg::MULT_25X) ? serdes_prov_pkg::MUL_X25 : // RL6
                        (r[3:0] == serdes_prov_pkg::MULT_20X) ? serdes_prov_pkg::MUL_X20 :
                        serdes_prov_pkg::MUL_NONE;
      nxt_cfg[c].loop_width = r[serdes_prov_pkg::LOOP_LSB +: 2]; // RL9
      nxt_cfg[c].post = e[serdes_prov_pkg::POST_LSB +: 5];
      nxt_cfg[c].pre = e[serdes_prov_pkg::PRE_LSB +: 4];
      nxt_cfg[c].swing = e[serdes_prov_pkg::SWING_LSB +: 4];
      nxt_cfg[c].eq_preset = regs_ff[c][6][serdes_prov_pkg::EQ_PRE_LSB +: 3];
      nxt_cfg[c].rec_thr = regs_ff[c][6][serdes_prov_pkg::EQ_THR_LSB +: 2];
      nxt_cfg[c].rec_fmult = regs_ff[c][6][serdes_prov_pkg::EQ_FM_LSB +: 2];
      nxt_cfg[c].term = o[serdes_prov_pkg::OVL_TERM_LSB +: 2]; // RL18
      nxt_cfg[c].slew = o[serdes_prov_pkg::OVL_SLEW]; // RL19
      nxt_cfg[c].receiver_on = regs_ff[c][7][serdes_prov_pkg::RXEN_ON];
      nxt_cfg[c].comma_en = a[serdes_prov_pkg::ALN_COMMA]; // RL10
      nxt_cfg[c].ten_bit = a[serdes_prov_pkg::ALN_TENBIT];
      nxt_cfg[c].ddr_en = a[serdes_prov_pkg::ALN_DDR]; // RL11
      nxt_cfg[c].tx_edge = a[serdes_prov_pkg::ALN_TXEDGE];
      nxt_cfg[c].rx_edge = a[serdes_prov_pkg::ALN_RXEDGE];
      nxt_cfg[c].path_clear = clr_ff[c];
      // Live conditions, so the pin tracks real time
      nxt_pin[c] = (o[serdes_prov_pkg::OVL_LOS] & cond[c].signal_absent) | // RL12 RL22
                   (o[serdes_prov_pkg::OVL_SYNC] & cond[c].sync) |
                   (o[serdes_prov_pkg::OVL_LOCK] & cond[c].pll_lock) |
                   (x[serdes_prov_pkg::OVLX_AGC] & ~cond[c].gain_loop_settled) |
                   (x[serdes_prov_pkg::OVLX_AZ] & cond[c].autozero_complete);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg_ff[0] <= '0;
      cfg_ff[1] <= '0;
      pin_ff <= 2'b00;
    end else begin
      cfg_ff <= nxt_cfg;
      pin_ff <= nxt_pin;
    end
  end

  assign cfg_a = cfg_ff[0];
  assign cfg_b = cfg_ff[1];
  assign status_pin_a = pin_ff[0];
  assign status_pin_b = pin_ff[1];
  assign mdio_out = out_ff;
  assign mdio_oe_n = oe_n_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mdio_drive_a: assert property (@(posedge core_clk) disable iff (!nrst) // MDIO pin driven only in turnaround and read data
    !oe_n_ff |-> (st_ff == serdes_prov_pkg::F_TA || st_ff == serdes_prov_pkg::F_RD))
    else $error("mdio driven outside read");
  global_write_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
    (wr_go && wslot[3] && glob_ff[serdes_prov_pkg::GL_GWRITE] && !soft_ff &&
     adr_ff != serdes_prov_pkg::REG_DPRST)
    |=> regs_ff[0][$past(wslot[2:0])] == regs_ff[1][$past(wslot[2:0])])
    else $error("global write missed a channel");
  ref_select_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL4
    (wr_go && adr_ff == serdes_prov_pkg::REG_GLOBAL && !wr_data[15])
    |=> ##1 cfg_ff[0].ref_sel == $past(wr_data[1], 2))
    else $error("reference select wrong");
  mult_decode_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
    cfg_ff[0].mult == serdes_prov_pkg::MUL_X25 |-> $past(regs_ff[0][0][3:0]) == 4'hE)
    else $error("multiplier decode wrong");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (!nrst || soft_ff) // RL20
    (cond[0].signal_absent && !rd_clr[0]) ##1 !rd_clr[0] |=> lat_ff[0].signal_absent)
    else $error("latched bit dropped");
  read_clear_a: assert property (@(posedge core_clk) disable iff (!nrst || soft_ff) // RL16
    (rd_clr[0] && !cond[0].rx_over) |=> !lat_ff[0].rx_over)
    else $error("read did not clear");
  overlay_pin_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL22
    (regs_ff[1][4][serdes_prov_pkg::OVL_LOS] && cond[1].signal_absent) |=> status_pin_b)
    else $error("overlay pin missing");
  path_clear_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL15
    (wr_go && adr_ff == serdes_prov_pkg::REG_DPRST && wr_data[3] && !ch_ff)
    |=> ##1 cfg_ff[0].path_clear)
    else $error("datapath clear not pulsed");
  soft_reset_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL2
    soft_ff |=> (glob_ff == 16'h0000 && regs_ff[1][2] == 16'h0180))
    else $error("soft reset incomplete");
endmodule : serdes_channel_provisioning
`default_nettype wire

/* mdio_host_model.sv */
// Management host model: sends clause-22 style MDIO frames.
// Assumes its tasks are called just after a core_clk rising edge.
`default_nettype none
module mdio_host_model (
  // Clock
  input wire logic core_clk,
  // Device pins
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output var logic mdc,
  output wire logic mdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_en = 1'b0;
  logic host_bit = 1'b1;
  // ------------------
  // Wire and frames
  // ------------------
  // Pull-up holds the line high when nobody drives it
  assign mdio_in = !mdio_oe_n ? mdio_out : (host_en ? host_bit : 1'b1);
  initial mdc = 1'b0;
  // Data moves with the falling MDC, so it is settled well before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= -1; i--) begin
      mdc <= 1'b0;
      host_en <= (i > 17) || (op == serdes_prov_pkg::OP_WR && i >= 0);
      host_bit <= (i >= 0) ? bits[i] : 1'b1;
      repeat (4) @(posedge core_clk);
      if (i >= 0 && i < 16) rd = {rd[14:0], mdio_in};
      mdc <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    // Clock stands still between frames
    mdc <= 1'b0;
    host_en <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : frame
endmodule : mdio_host_model
`default_nettype wire

/* serdes_channel_provisioning_bench.sv */
// Self-checking bench for the two-channel provisioning register bank.
// Assumes the package and the MDIO host model are compiled first.
`default_nettype none
module serdes_channel_provisioning_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic nrst;
  logic mdc;
  wire logic mdio_in;
  logic mdio_out;
  logic mdio_oe_n;
  serdes_prov_pkg::chan_stat_t stat_a;
  serdes_prov_pkg::chan_stat_t stat_b;
  serdes_prov_pkg::chan_cfg_t cfg_a;
  serdes_prov_pkg::chan_cfg_t cfg_b;
  logic status_pin_a;
  logic status_pin_b;
  int num_errors = 0;
  int check_count = 0;
  int clr_a = 0;
  int clr_b = 0;
  int n_a;
  int n_b;
  logic [15:0] rdv;
  // Rate word, then expected transmit and receive divider codes
  logic [19:0] rows [9] = '{20'h010E0, 20'h010D0, 20'h015E5, 20'h015D5, 20'h01AEA,
                            20'h01ADA, 20'h01FEF, 20'h01FDF, 20'h01969};
  logic [15:0] aln [3] = '{16'h0183, 16'h01C0, 16'h01C3};
  // Expected pin level, then condition bits flipped from the quiet state
  logic [9:0] ovl [6] = '{10'h204, 10'h202, 10'h201, 10'h280, 10'h300, 10'h040};

  serdes_channel_provisioning #(.PHY_BASE(4'h3)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .stat_a(stat_a), .stat_b(stat_b), .cfg_a(cfg_a), .cfg_b(cfg_b),
    .status_pin_a(status_pin_a), .status_pin_b(status_pin_b));
  mdio_host_model u_host (
    .core_clk(core_clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));
  // ------------------
  // Clock, watchdog, monitors
  // ------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // About forty frames of some 530 cycles each; generous margin
  initial begin
    repeat (80000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  always @(posedge core_clk) begin
    if (cfg_a.path_clear === 1'b1) clr_a++;
    if (cfg_b.path_clear === 1'b1) clr_b++;
  end
  // ------------------
  // Tasks
  // ------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic ch, input logic [4:0] rg, input logic [15:0] d);
    logic [15:0] x;
    u_host.frame(serdes_prov_pkg::OP_WR, {4'h3, ch}, rg, d, x);
  endtask : wr
  task automatic rchk(input logic ch, input logic [4:0] rg, input logic [15:0] exp, input string what);
    logic [15:0] d;
    u_host.frame(serdes_prov_pkg::OP_RD, {4'h3, ch}, rg, 16'h0000, d);
    chk(what, exp, d);
  endtask : rchk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  function automatic serdes_prov_pkg::mult_t exp_mult(input logic [3:0] m);
    if (m == 4'hE) return serdes_prov_pkg::MUL_X25;
    if (m == 4'hD) return serdes_prov_pkg::MUL_X20;
    return serdes_prov_pkg::MUL_NONE;
  endfunction : exp_mult
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ------------------
  // Sequence
  // ------------------
  initial begin
    nrst = 1'b0;
    stat_a = '0;
    stat_b = 9'h080;
    tick(5);
    nrst <= 1'b1;
    tick(3);
    chk("comma", 16'h1, cfg_a.comma_en);
    chk("ten bit", 16'h1, cfg_b.ten_bit);
    chk("edge mode", 16'h0, {cfg_a.ddr_en, cfg_a.tx_edge, cfg_a.rx_edge});
    chk("threshold", 16'h1, cfg_a.rec_thr);
    rchk(1'b0, serdes_prov_pkg::REG_ALIGN, 16'h0180, "align word");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(1'b0, serdes_prov_pkg::REG_RATE, rows[i][19:4]);
      chk("tx rate", rows[i][3:2], cfg_a.tx_rate);
      chk("rx rate", rows[i][1:0], cfg_a.rx_rate);
      chk("mult", exp_mult(rows[i][7:4]), cfg_a.mult);
      chk("mult b", exp_mult(4'hE), cfg_b.mult);
      rchk(1'b0, serdes_prov_pkg::REG_RATE, rows[i][19:4], "rate word");
    end
    foreach (aln[i]) begin
      wr(1'b1, serdes_prov_pkg::REG_ALIGN, aln[i]);
      chk("align b", {aln[i][6], aln[i][1:0]}, {cfg_b.ddr_en, cfg_b.tx_edge, cfg_b.rx_edge});
    end
    $display("test table done");
    wr(1'b0, serdes_prov_pkg::REG_GLOBAL, 16'h0802);
    chk("ref a", 16'h1, cfg_a.ref_sel);
    chk("ref b", 16'h0, cfg_b.ref_sel);
    wr(1'b0, serdes_prov_pkg::REG_EMPH, 16'h1A5C);
    chk("emph b", 16'h1A5C, {cfg_b.post, cfg_b.pre, cfg_b.swing});
    wr(1'b0, serdes_prov_pkg::REG_EQ, 16'h5600);
    chk("eq b", 16'h0056, {cfg_b.eq_preset, cfg_b.rec_thr, cfg_b.rec_fmult});
    wr(1'b0, serdes_prov_pkg::REG_RATE, 16'h030E);
    chk("loop b", 16'h3, cfg_b.loop_width);
    wr(1'b0, serdes_prov_pkg::REG_GLOBAL, 16'h0001);
    chk("ref a off", 16'h0, cfg_a.ref_sel);
    chk("ref b on", 16'h1, cfg_b.ref_sel);
    wr(1'b0, serdes_prov_pkg::REG_RXEN, 16'h0000);
    chk("rx off a", 16'h0, cfg_a.receiver_on);
    chk("rx on b", 16'h1, cfg_b.receiver_on);
    wr(1'b0, serdes_prov_pkg::REG_RXEN, 16'h0004);
    chk("rx on a", 16'h1, cfg_a.receiver_on);
    $display("test global done");
    wr(1'b1, serdes_prov_pkg::REG_OVL, 16'h0707);
    wr(1'b1, serdes_prov_pkg::REG_OVLX, 16'h00C0);
    chk("term", 16'h3, cfg_b.term);
    chk("slew", 16'h1, cfg_b.slew);
    foreach (ovl[i]) begin
      stat_b <= 9'h080 ^ ovl[i][8:0];
      tick(6);
      chk("pin b", ovl[i][9], status_pin_b);
      chk("pin a", 16'h0, status_pin_a);
      stat_b <= 9'h080;
      tick(6);
      chk("pin b idle", 16'h0, status_pin_b);
    end
    $display("test overlay done");
    stat_a <= '1;
    tick(6);
    rchk(1'b0, serdes_prov_pkg::REG_STAT, 16'h60F7, "status all");
    stat_a <= '0;
    tick(6);
    rchk(1'b0, serdes_prov_pkg::REG_STAT, 16'h60F6, "status held");
    rchk(1'b0, serdes_prov_pkg::REG_STAT, 16'h0000, "status cleared");
    $display("test status done");
    n_a = clr_a;
    n_b = clr_b;
    wr(1'b0, serdes_prov_pkg::REG_DPRST, 16'h0008);
    chk("clear a", 16'h1, 16'(clr_a - n_a));
    chk("clear b", 16'h0, 16'(clr_b - n_b));
    n_a = clr_a;
    n_b = clr_b;
    wr(1'b0, serdes_prov_pkg::REG_GLOBAL, 16'h8000);
    chk("soft clears", 16'h2, 16'((clr_a - n_a) + (clr_b - n_b)));
    chk("ref b reset", 16'h0, cfg_b.ref_sel);
    rchk(1'b0, serdes_prov_pkg::REG_RATE, 16'h010E, "rate reset");
    rchk(1'b0, serdes_prov_pkg::REG_GLOBAL, 16'h0000, "global reset");
    u_host.frame(serdes_prov_pkg::OP_WR, 5'h04, serdes_prov_pkg::REG_RATE, 16'h01FD, rdv);
    rchk(1'b0, serdes_prov_pkg::REG_RATE, 16'h010E, "foreign address");
    rchk(1'b0, 5'h1F, 16'h0000, "unmapped");
    stat_a <= 9'h181;
    tick(6);
    rchk(1'b0, serdes_prov_pkg::REG_STAT, 16'h6001, "gain locked");
    wr(1'b0, serdes_prov_pkg::REG_EQ, 16'h0500);
    chk("fmult", 16'h1, cfg_a.rec_fmult);
    nrst <= 1'b0;
    tick(5);
    nrst <= 1'b1;
    tick(3);
    chk("fmult reset", 16'h0, cfg_a.rec_fmult);
    rchk(1'b0, serdes_prov_pkg::REG_EQ, 16'h0400, "eq reset");
    $display("test reset and refusal done");
    conclude();
  end
endmodule : serdes_channel_provisioning_bench
`default_nettype wire
